// ===== rlr_pkg.sv
/*
 Constants, register map and state codes of the raw long-read command block.
 Assumes a single pclk domain and an APB master reaching the registers.
*/
// Functional notes
// RULE1: The 10-byte form has opcode 3Eh, flags in byte 1, LBA in bytes 2-5, length in 7-8, MSB first.
// RULE2: The 16-byte form has opcode 9Eh, action 11h, LBA in 2-9, length in 12-13, flags in byte 14.
// RULE3: A good long read sends exactly one block: user data then its media error check bytes.
// RULE4: With a non-zero exponent and the whole-block bit set, the whole physical block is returned.
// RULE5: With a non-zero exponent and the whole-block bit clear, only the logical block is returned.
// RULE6: A zero exponent with the whole-block bit set ends in illegal request, invalid field in CDB.
// RULE7: With the report bit clear, data returns with no media error whatever the correction result.
// RULE8: With the report bit set, a failed correction is reported as a media error.
// RULE9: A non-zero length unequal to the available length ends in illegal request, invalid field.
// RULE10: On a length mismatch the valid and ILI flags are set and info holds requested minus actual.
// RULE11: A negative length difference is held in two's complement.
// RULE12: The initiator asks for exactly the available length, derived from the logical block size.
// RULE13: Long-read data bypasses the cache both for reading and for keeping.
// RULE14: Block exponent and logical block size are static configuration inputs.
// RULE15: The checks finish before any data moves, so a rejected command sends nothing.
package rlr_pkg;
    localparam logic [7:0] OP_LONG10 = 8'h3e;
    localparam logic [7:0] OP_LONG16 = 8'h9e;
    localparam logic [4:0] SA_LONG = 5'h11;
    localparam int BIT_WHOLE = 2;
    localparam int BIT_REPORT = 1;
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_MEDIUM = 4'h3;
    localparam logic [3:0] KEY_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_UNRECOVERED = 8'h11;
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CDB0 = 8'h04;
    localparam logic [7:0] OFF_CDB3 = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_SENSE = 8'h18;
    localparam logic [7:0] OFF_INFO = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFF_COUNT = 8'h28;
    localparam int CTRL_START = 0;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CHECK = 1;
    localparam int IRQ_W = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    typedef enum logic [4:0] {
        RLR_IDLE = 5'b00001,
        RLR_CHECK = 5'b00010,
        RLR_REQ = 5'b00100,
        RLR_XFER = 5'b01000,
        RLR_DONE = 5'b10000
    } rlr_state_e;
endpackage

// ===== rlr_top.sv
/*
 Raw long-read command interpreter: APB registers hold the command block,
 the block checks it, fetches one block from the media port and streams it
 to the initiator, then reports status and sense data.
 Assumes media and initiator streams run on pclk, and the geometry inputs
 stay still while a command runs.
*/
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module rlr_top
    import rlr_pkg::*;
#(
    parameter int LEN_W = 16,
    parameter int EXP_W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EXP_W-1:0] cfg_block_exponent,
    input wire logic [LEN_W-1:0] cfg_logical_block_size,
    input wire logic [LEN_W-1:0] cfg_check_bytes,
    output logic media_req,
    output logic [63:0] media_lba,
    output logic media_whole_physical,
    output logic media_cache_bypass,
    output logic [31:0] media_len,
    input wire logic media_valid,
    input wire logic [7:0] media_data,
    input wire logic media_uncorrected,
    output logic media_ready,
    output logic host_valid,
    output logic [7:0] host_data,
    input wire logic host_ready,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] cdb_byte(input logic [127:0] v, input int i);
        cdb_byte = v[127-8*i -: 8];
    endfunction

    rlr_state_e state;
    logic [31:0] cdb_w [4];
    logic [127:0] cdb;
    logic apb_wr;
    logic apb_rd;
    logic start;
    logic [7:0] status_byte;
    logic sense_valid;
    logic sense_ili;
    logic [3:0] sense_key;
    logic [7:0] sense_asc;
    logic [31:0] info;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0] sent;
    logic [31:0] want;
    logic report_uncorrected_bit;
    logic uncorr_seen;

    assign cdb = {cdb_w[0], cdb_w[1], cdb_w[2], cdb_w[3]};
    assign apb_wr = psel & penable & pready & pwrite;
    assign apb_rd = psel & ~penable & ~pwrite;
    assign start = apb_wr && paddr == OFF_CTRL && pwdata[CTRL_START] && state == RLR_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Command block decode
    logic [7:0] op;
    logic is10;
    logic is16;
    logic whole_physical_block_bit;
    logic report_bit;
    logic [63:0] lba;
    logic [LEN_W-1:0] req_len;
    logic [31:0] logical_len;
    logic [31:0] avail;
    logic [31:0] diff;

    always_comb begin
        op = cdb_byte(cdb, 0);
        is10 = op == OP_LONG10;                                       // RULE1
        is16 = op == OP_LONG16 && 5'(cdb_byte(cdb, 1)) == SA_LONG;   // RULE2
        if (is16) begin
            lba = {cdb_byte(cdb, 2), cdb_byte(cdb, 3), cdb_byte(cdb, 4), cdb_byte(cdb, 5),
                cdb_byte(cdb, 6), cdb_byte(cdb, 7), cdb_byte(cdb, 8), cdb_byte(cdb, 9)}; // RULE2
            req_len = LEN_W'({cdb_byte(cdb, 12), cdb_byte(cdb, 13)});                // RULE2
            whole_physical_block_bit = 1'(cdb_byte(cdb, 14) >> BIT_WHOLE);           // RULE2
            report_bit = 1'(cdb_byte(cdb, 14) >> BIT_REPORT);
        end else begin
            lba = {32'h0, cdb_byte(cdb, 2), cdb_byte(cdb, 3), cdb_byte(cdb, 4),
                cdb_byte(cdb, 5)};                                                   // RULE1
            req_len = LEN_W'({cdb_byte(cdb, 7), cdb_byte(cdb, 8)});                  // RULE1
            whole_physical_block_bit = 1'(cdb_byte(cdb, 1) >> BIT_WHOLE);            // RULE1
            report_bit = 1'(cdb_byte(cdb, 1) >> BIT_REPORT);
        end
        // Geometry is taken live from the static inputs
        logical_len = 32'(cfg_logical_block_size) + 32'(cfg_check_bytes);          // RULE14
        if (cfg_block_exponent != '0 && whole_physical_block_bit) begin
            avail = logical_len << cfg_block_exponent;                             // RULE4
        end else begin
            avail = logical_len;                                                   // RULE5
        end
        diff = 32'(req_len) - avail;                                               // RULE11
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RLR_IDLE;
        end else begin
            case (state)
                RLR_IDLE: begin
                    if (start) begin
                        state <= RLR_CHECK;
                    end
                end
                RLR_CHECK: begin
                    // Every rejection is decided here, before the media is asked
                    if (!(is10 || is16)) begin
                        state <= RLR_DONE;
                    end else if (cfg_block_exponent == '0 && whole_physical_block_bit) begin
                        state <= RLR_DONE;                                         // RULE6
                    end else if (req_len != '0 && 32'(req_len) != avail) begin
                        state <= RLR_DONE;                                         // RULE9
                    end else begin
                        state <= RLR_REQ;                                          // RULE15
                    end
                end
                RLR_REQ: begin
                    state <= RLR_XFER;
                end
                RLR_XFER: begin
                    if (host_valid && host_ready && sent + 32'h1 == want) begin
                        state <= RLR_DONE;                                         // RULE3
                    end
                end
                default: begin
                    state <= RLR_IDLE;
                end
            endcase
        end
    end

    // Status and sense result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_byte <= ST_GOOD;
            sense_valid <= 1'b0;
            sense_ili <= 1'b0;
            sense_key <= KEY_NONE;
            sense_asc <= ASC_NONE;
            info <= 32'h0;
            report_uncorrected_bit <= 1'b0;
        end else if (start) begin
            status_byte <= ST_GOOD;
            sense_valid <= 1'b0;
            sense_ili <= 1'b0;
            sense_key <= KEY_NONE;
            sense_asc <= ASC_NONE;
            info <= 32'h0;
        end else if (state == RLR_CHECK) begin
            report_uncorrected_bit <= report_bit;
            if (!(is10 || is16)) begin
                status_byte <= ST_CHECK;
                sense_key <= KEY_ILLEGAL;
                sense_asc <= ASC_BAD_OPCODE;
            end else if (cfg_block_exponent == '0 && whole_physical_block_bit) begin
                status_byte <= ST_CHECK;                                           // RULE6
                sense_key <= KEY_ILLEGAL;
                sense_asc <= ASC_BAD_FIELD;
            end else if (req_len != '0 && 32'(req_len) != avail) begin
                status_byte <= ST_CHECK;                                           // RULE9
                sense_key <= KEY_ILLEGAL;
                sense_asc <= ASC_BAD_FIELD;
                sense_valid <= 1'b1;                                               // RULE10
                sense_ili <= 1'b1;                                                 // RULE10
                info <= diff;                                                      // RULE11
            end
        end else if (state == RLR_XFER && host_valid && host_ready && sent + 32'h1 == want) begin
            // Correction failures stay silent unless the initiator asked for them
            if (report_uncorrected_bit && (uncorr_seen || media_uncorrected)) begin
                status_byte <= ST_CHECK;                                           // RULE8
                sense_key <= KEY_MEDIUM;
                sense_asc <= ASC_UNRECOVERED;
            end                                                                    // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Media request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            media_req <= 1'b0;
            media_lba <= 64'h0;
            media_whole_physical <= 1'b0;
            media_cache_bypass <= 1'b0;
            media_len <= 32'h0;
            want <= 32'h0;
        end else begin
            media_req <= state == RLR_CHECK && (is10 || is16)
                && !(cfg_block_exponent == '0 && whole_physical_block_bit)
                && !(req_len != '0 && 32'(req_len) != avail);                      // RULE15
            if (state == RLR_CHECK) begin
                media_lba <= lba;
                media_whole_physical <= whole_physical_block_bit;                  // RULE4
                media_cache_bypass <= 1'b1;                                        // RULE13
                media_len <= avail;
                want <= avail;                                                     // RULE3
            end
        end
    end

    // Single stage between media and initiator; ready is precomputed so
    // that it can leave a flip-flop, at the cost of some throughput.
    logic next_host_valid;
    logic take_media;

    assign take_media = media_valid && media_ready;

    always_comb begin
        next_host_valid = host_valid;
        if (host_valid && host_ready) begin
            next_host_valid = 1'b0;
        end
        if (take_media) begin
            next_host_valid = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_valid <= 1'b0;
            host_data <= 8'h00;
            media_ready <= 1'b0;
        end else begin
            host_valid <= next_host_valid;
            if (take_media) begin
                host_data <= media_data;
            end
            // Only bytes of the one block are accepted
            media_ready <= state == RLR_XFER && !next_host_valid
                && sent + 32'(next_host_valid) < want
                && !(host_valid && host_ready && sent + 32'h1 == want);             // RULE3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sent <= 32'h0;
            uncorr_seen <= 1'b0;
        end else if (state == RLR_CHECK) begin
            sent <= 32'h0;
            uncorr_seen <= 1'b0;
        end else begin
            if (host_valid && host_ready) begin
                sent <= sent + 32'h1;
            end
            if (take_media && media_uncorrected) begin
                uncorr_seen <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over a write-one clear
    assign irq_set[IRQ_DONE] = state == RLR_DONE;
    assign irq_set[IRQ_CHECK] = state == RLR_DONE && status_byte == ST_CHECK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            if (apb_wr && paddr == OFF_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            if (apb_wr && paddr == OFF_IRQ_MASK) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: answers in the first access cycle; writes land at that edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                cdb_w[i] <= 32'h0;
            end
        end else if (apb_wr && paddr >= OFF_CDB0 && paddr <= OFF_CDB3
            && paddr[1:0] == 2'b00 && state == RLR_IDLE) begin
            // Command block is frozen while a command runs
            cdb_w[2'(paddr[7:2] - 6'h1)] <= pwdata;
        end
    end

    logic mapped;
    logic [31:0] rd_val;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0;
        if (paddr == OFF_CTRL) begin
            rd_val = {31'h0, state != RLR_IDLE};
        end else if (paddr >= OFF_CDB0 && paddr <= OFF_CDB3 && paddr[1:0] == 2'b00) begin
            rd_val = cdb_w[2'(paddr[7:2] - 6'h1)];
        end else if (paddr == OFF_STATUS) begin
            rd_val = {19'h0, state, status_byte};
        end else if (paddr == OFF_SENSE) begin
            rd_val = {16'h0, sense_valid, sense_ili, 2'h0, sense_key, sense_asc};
        end else if (paddr == OFF_INFO) begin
            rd_val = info;
        end else if (paddr == OFF_IRQ_STAT) begin
            rd_val = {30'h0, irq_stat};
        end else if (paddr == OFF_IRQ_MASK) begin
            rd_val = {30'h0, irq_mask};
        end else if (paddr == OFF_COUNT) begin
            rd_val = sent;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (apb_rd) begin
                prdata <= rd_val;
            end
        end
    end

endmodule

// ===== rlr_chk.sv
/*
 Port checker for the long-read command block.
 Bound into rlr_top; one pclk domain, async active-low reset.
*/
`timescale 1ns/10ps
module rlr_chk
    import rlr_pkg::*;
#(
    parameter int LEN_W = 16,
    parameter int EXP_W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [EXP_W-1:0] cfg_block_exponent,
    input wire logic [LEN_W-1:0] cfg_logical_block_size,
    input wire logic [LEN_W-1:0] cfg_check_bytes,
    input wire logic media_req,
    input wire logic media_whole_physical,
    input wire logic media_cache_bypass,
    input wire logic [31:0] media_len,
    input wire logic media_valid,
    input wire logic media_ready,
    input wire logic host_valid,
    input wire logic [7:0] host_data,
    input wire logic host_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    // Bytes handed over since the last media request
    logic [31:0] cnt;
    logic on;
    logic [EXP_W-1:0] sh;
    logic [31:0] avail;
    assign sh = media_whole_physical ? cfg_block_exponent : '0;
    assign avail = (32'(cfg_logical_block_size) + 32'(cfg_check_bytes)) << sh;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            on <= 1'b0;
        end else if (media_req) begin
            cnt <= '0;
            on <= 1'b1;
        end else if (host_valid && host_ready) begin
            cnt <= cnt + 32'h1;
            on <= (cnt + 32'h1 != media_len);
        end
    end
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_bypass; media_req |-> media_cache_bypass; endproperty
    a_bypass: assert property (p_bypass) else $error("cache used");
    property p_len; media_req |-> media_len == avail; endproperty
    a_len: assert property (p_len) else $error("bad media length");
    property p_exp0; media_req |-> !(media_whole_physical && cfg_block_exponent == '0); endproperty
    a_exp0: assert property (p_exp0) else $error("whole block at zero exponent");
    property p_hold; host_valid && !host_ready |=> host_valid && $stable(host_data); endproperty
    a_hold: assert property (p_hold) else $error("host byte dropped");
    property p_pass; media_valid && media_ready |=> host_valid; endproperty
    a_pass: assert property (p_pass) else $error("media byte not forwarded");
    property p_count; host_valid |-> on && cnt < media_len; endproperty
    a_count: assert property (p_count) else $error("byte outside block");
    c_whole: cover property (media_req && media_whole_physical);
    c_stall: cover property (host_valid && !host_ready);
    c_err: cover property (pslverr);
endmodule
bind rlr_top rlr_chk #(.LEN_W(LEN_W), .EXP_W(EXP_W)) u_chk (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .cfg_block_exponent, .cfg_logical_block_size, .cfg_check_bytes,
    .media_req, .media_whole_physical, .media_cache_bypass, .media_len, .media_valid,
    .media_ready, .host_valid, .host_data, .host_ready);

// ===== rlr_host_model.sv
/*
 Initiator model: takes host bytes into a queue.
 Stalls three cycles in four when stall_en is high.
*/
`timescale 1ns/10ps
module rlr_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic host_valid,
    input wire logic [7:0] host_data,
    input wire logic stall_en,
    output logic host_ready
);
    ////////////////////////////////////////////////////////////
    logic [7:0] rx_q[$];
    logic [1:0] ph;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= '0;
            host_ready <= 1'b0;
        end else begin
            if (host_valid && host_ready) rx_q.push_back(host_data);
            ph <= ph + 2'h1;
            host_ready <= !stall_en || ph == 2'h3;
        end
    end
endmodule

// ===== raw_block_read_long_cmd_tb.sv
/*
 Self-checking bench for rlr_top: APB master, media source, initiator model.
 Random geometry and request lengths from a fixed seed; command forms follow the loop index.
*/
`timescale 1ns/10ps
module raw_block_read_long_cmd_tb;
    import rlr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall_en = 0;
    logic [7:0] paddr = '0, media_data = '0, host_data, st, asc;
    logic [31:0] pwdata = '0, prdata, media_len, q, avail, rlen;
    logic pready, pslverr, media_req, media_whole_physical, media_cache_bypass, media_ready;
    logic host_valid, host_ready, irq, err, media_valid = 0, media_uncorrected = 0, unc = 0;
    logic whole, rep, f16, chg, lenerr;
    logic [63:0] media_lba, got_lba = '0, lba;
    logic [3:0] cfg_block_exponent = '0, key;
    logic [15:0] cfg_logical_block_size = 16'h8, cfg_check_bytes = 16'h2;
    logic [7:0] cdb[16];
    int n_fail = 0, checks_done = 0, m_left = 0, m_k = 0, n_req = 0, r0, ex, lbs, mode, bad;
    always #12.5 pclk = ~pclk;
    rlr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cfg_block_exponent, .cfg_logical_block_size, .cfg_check_bytes, .media_req,
        .media_lba, .media_whole_physical, .media_cache_bypass, .media_len, .media_valid,
        .media_data, .media_uncorrected, .media_ready, .host_valid, .host_data, .host_ready,
        .irq);
    rlr_host_model far (.pclk, .presetn, .host_valid, .host_data, .stall_en, .host_ready);
    ////////////////////////////////////////////////////////////
    // Media source; a released data line shows the inverse of its last byte
    always @(posedge pclk) begin
        if (media_req) begin
            n_req <= n_req + 1;
            got_lba <= media_lba;
            m_left <= int'(media_len);
            m_k <= 0;
            media_valid <= 1'b1;
            media_data <= 8'ha5;
            media_uncorrected <= unc;
        end else if (media_valid && media_ready) begin
            m_k <= m_k + 1;
            media_valid <= (m_k + 1 != m_left);
            media_data <= (m_k + 1 == m_left) ? ~media_data : 8'(m_k + 1) ^ 8'ha5;
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 40000);
        n_fail++;
        final_report();
    end
    initial begin
        void'($urandom(90));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h3c, '0);
        chk(32'(err), 32'h1);
        chk(q, '0);
        apb(1, OFF_IRQ_MASK, 32'h3);
        for (int i = 0; i < 24; i++) begin
            f16 = i[0];
            whole = i[1];
            rep = i[2];
            bad = i == 21 ? 1 : i == 23 ? 2 : 0;
            ex = $urandom % 3;
            lbs = 4 + $urandom % 9;
            mode = $urandom % 4;
            lba = {$urandom, $urandom};
            if (!f16) lba[63:32] = '0;
            avail = lbs + 2;
            if (ex != 0 && whole) avail = avail << ex;
            rlen = mode == 0 ? 0 : mode == 1 ? avail : mode == 2 ? avail + 1 : avail - 3;
            cdb = '{default: 8'h00};
            cdb[0] = bad == 1 ? 8'h9f : f16 ? OP_LONG16 : OP_LONG10;
            if (f16) begin
                cdb[1] = {3'h0, bad == 2 ? 5'h12 : SA_LONG};
                for (int b = 0; b < 8; b++) cdb[2 + b] = lba[63 - 8 * b -: 8];
                {cdb[12], cdb[13]} = rlen[15:0];
                cdb[14] = {5'h0, whole, rep, 1'b0};
            end else begin
                cdb[1] = {5'h0, whole, rep, 1'b0};
                for (int b = 0; b < 4; b++) cdb[2 + b] = lba[31 - 8 * b -: 8];
                {cdb[7], cdb[8]} = rlen[15:0];
            end
            cfg_block_exponent <= 4'(ex);
            cfg_logical_block_size <= 16'(lbs);
            stall_en <= 1'($urandom % 2);
            unc <= 1'($urandom % 2);
            far.rx_q.delete();
            r0 = n_req;
            for (int j = 0; j < 4; j++)
                apb(1, OFF_CDB0 + 8'(4 * j), {cdb[4 * j], cdb[4 * j + 1], cdb[4 * j + 2],
                    cdb[4 * j + 3]});
            apb(1, OFF_CTRL, 32'h1);
            for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge pclk);
            chk(32'(irq), 32'h1);
            lenerr = bad == 0 && !(ex == 0 && whole) && rlen != 0 && rlen != avail;
            chg = bad != 0 || (ex == 0 && whole) || lenerr;
            {st, key, asc} = bad != 0 ? {ST_CHECK, KEY_ILLEGAL, ASC_BAD_OPCODE}
                : chg ? {ST_CHECK, KEY_ILLEGAL, ASC_BAD_FIELD}
                : rep && unc ? {ST_CHECK, KEY_MEDIUM, ASC_UNRECOVERED}
                : {ST_GOOD, KEY_NONE, ASC_NONE};
            apb(0, OFF_IRQ_STAT, '0);
            chk(32'(q[1:0]), {30'h0, st == ST_CHECK, 1'b1});
            apb(1, OFF_IRQ_MASK, 32'h0);
            repeat (2) @(negedge pclk);
            chk(32'(irq), 32'h0);
            apb(1, OFF_IRQ_MASK, 32'h3);
            apb(1, OFF_IRQ_STAT, 32'h3);
            repeat (2) @(negedge pclk);
            chk(32'(irq), 32'h0);
            apb(0, OFF_STATUS, '0);
            chk(32'(q[7:0]), 32'(st));
            apb(0, OFF_SENSE, '0);
            chk(32'(q[11:0]), {20'h0, key, asc});
            chk(32'(q[15:14]), lenerr ? 32'h3 : 32'h0);
            if (lenerr) begin
                apb(0, OFF_INFO, '0);
                chk(q, rlen - avail);
            end
            chk(32'(far.rx_q.size()), chg ? 0 : avail);
            chk(n_req - r0, chg ? 0 : 1);
            foreach (far.rx_q[k]) chk(32'(far.rx_q[k]), 32'(8'(k) ^ 8'ha5));
            if (!chg) begin
                chk(got_lba[63:32], lba[63:32]);
                chk(got_lba[31:0], lba[31:0]);
                chk(32'(media_cache_bypass), 32'h1);
            end
        end
        final_report();
    end
endmodule
